// >>> rtl/hcr_pkg.sv
// package: offsets, field positions, reset values and types of the host config registers
package hcr_pkg;
  // host i/o register offsets
  localparam logic [3:0] HCR_OFS_CMD   = 4'h0;
  localparam logic [3:0] HCR_OFS_STAT  = 4'h2;
  localparam logic [3:0] HCR_OFS_CTRL  = 4'h6;
  localparam logic [3:0] HCR_OFS_PAGE  = 4'h8;
  // setup slot register indices
  localparam logic [2:0] HCR_OPT_ARB   = 3'h3;
  localparam logic [2:0] HCR_OPT_XCVR  = 3'h4;
  localparam logic [2:0] HCR_OPT_MISC  = 3'h5;
  localparam logic [2:0] HCR_OPT_SUBLO = 3'h6;
  localparam logic [2:0] HCR_OPT_SUBHI = 3'h7;
  // field positions
  localparam int HCR_STAT_EMPTY_BIT = 6;
  localparam int HCR_STAT_FULL_BIT  = 5;
  localparam int HCR_CTRL_ATTENTION_REQUEST_BIT  = 7;
  localparam int HCR_CTRL_RST_BIT   = 6;
  localparam int HCR_CTRL_IRQE_BIT  = 3;
  localparam int HCR_PAGE_SHIFT     = 12;
  // control register writable bits (reserved bits kept at zero)
  localparam logic [7:0] HCR_CTRL_MASK = 8'hC8;
  // reset values
  localparam logic [3:0] HCR_ARB_RESET = 4'hA;
  localparam logic [1:0] HCR_WSZ_RESET = 2'h0;
  localparam logic [1:0] HCR_IRQ_RESET = 2'h0;
  localparam logic [1:0] HCR_BND_RESET = 2'h0;
  // extended option space
  localparam logic [15:0] HCR_SUB_PROM_LO = 16'h0001;
  localparam logic [15:0] HCR_SUB_PROM_HI = 16'h00FF;
  localparam logic [15:0] HCR_SUB_CMP_LO  = 16'h0100;
  localparam logic [15:0] HCR_SUB_CMP_HI  = 16'h0104;
  localparam int          HCR_CMP_COUNT   = 5;

  // decoded setup options handed to the rest of the adapter
  typedef struct packed {
    logic [1:0] windowSizeSelect;
    logic       windowEnable;
    logic [3:0] arbitrationPriority;
    logic       fairnessEnable;
    logic       onboardTransceiverSelect;
    logic [1:0] burstBoundarySelect;
    logic [1:0] irqLevelSelect;
  } hcr_opt_t;

  // host i/o access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } hcr_io_t;
endpackage

// >>> rtl/host_config_regs.sv
// host-facing setup-slot option fields, subaddress port and host i/o registers
`timescale 1ns/1ps
module host_config_regs
  import hcr_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clkEn,
  // setup slot access (option registers)
  input  wire logic              optWr,
  input  wire logic              optRd,
  input  wire logic [2:0]        optAddr,
  input  wire logic [7:0]        optWdata,
  output logic      [7:0]        optRdata,
  // extended option space lookup (PROM)
  output logic      [7:0]        promAddr,
  input  wire logic [7:0]        promData,
  // host i/o register access
  input  wire hcr_io_t           hostIo,
  output logic      [7:0]        hostRdata,
  // local processor side of command register
  input  wire logic              lpWr,
  input  wire logic              lpRd,
  input  wire logic [7:0]        lpWdata,
  output logic      [7:0]        lpRdata,
  // host memory window access
  input  wire logic              winReq,
  input  wire logic [15:0]       winOffset,
  output logic                   winHit,
  output logic      [ADDR_W-1:0] winAdapterAddr,
  // decoded options and side effects
  output hcr_opt_t               opts,
  output logic      [6:0]        windowBytesK,
  output logic      [3:0]        hostIrqLevel,
  output logic      [6:0]        burstBytes,
  output logic      [39:0]       baseCompareBits,
  output logic                   hostIrq,
  output logic                   adapterNmi,
  output logic                   adapterHardReset
);

  initial begin
    if (ADDR_W < 20) $error("ADDR_W must hold page plus shift");
  end

  // ==================================================
  // ADDR_W covers the adapter-side address space; the page register supplies
  // eight bits above a twelve-bit page offset, so anything narrower than twenty
  // bits would silently drop page bits from the window translation.
  // wider buses are fine: the upper bits of the translated address stay zero apart from bit twenty, which takes the carry of the page plus offset sum.

  // ==================================================
  // reset release
  // arst_n comes straight off the host bus reset line and may drop at any time;
  // entry into reset is immediate, but release is retimed so that no flop sees
  // its reset leave within the setup window of a clock edge.
  // everything below uses rstN, never arst_n directly.
  // two flops so release is synchronous to clk
  logic rstSync1, rstSync2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  wire logic rstN = rstSync2;

  // ==================================================
  // state
  // opt_reg: decoded setup-slot option fields, survive the adapter hard reset
  // sub_reg: extended option space pointer, zero means normal register three
  // cmp_reg: extra base-address compare bytes behind the subaddress port
  // h2a/a2h: the two halves of the byte-wide command register
  // empty/full: handshake flags seen by the host in the status byte
  hcr_opt_t    opt_reg;
  logic [15:0] sub_reg;
  logic [7:0]  cmp_reg [HCR_CMP_COUNT];
  logic [7:0]  h2a_reg, a2h_reg, ctrl_reg, page_reg;
  logic        empty_reg, full_reg, hardRst_reg;

  // ==================================================
  // decode
  // host strobes are single-cycle and qualified by the offset here; clkEn is
  // applied in each process so a frozen cycle takes no write and no read.
  // register three writes split by the subaddress: zero hits the arbitration
  // byte, the compare range lands in cmp_reg, the prom range is read-only and
  // anything else in the extended space is simply dropped.
  wire logic hWr      = hostIo.wr;
  wire logic hRd      = hostIo.rd;
  wire logic hCmdWr   = hWr && hostIo.addr == HCR_OFS_CMD;
  wire logic hCmdRd   = hRd && hostIo.addr == HCR_OFS_CMD;
  wire logic hCtrlWr  = hWr && hostIo.addr == HCR_OFS_CTRL;
  wire logic hPageWr  = hWr && hostIo.addr == HCR_OFS_PAGE;
  wire logic subZero  = sub_reg == 16'h0000;
  wire logic subProm  = sub_reg >= HCR_SUB_PROM_LO && sub_reg <= HCR_SUB_PROM_HI;
  wire logic subCmp   = sub_reg >= HCR_SUB_CMP_LO && sub_reg <= HCR_SUB_CMP_HI;
  wire logic [2:0] cmpIdx = sub_reg[2:0];
  wire logic optWrArb = optWr && optAddr == HCR_OPT_ARB && subZero;
  wire logic optWrExt = optWr && optAddr == HCR_OPT_ARB && subCmp;
  // hard reset held while both attention and reset are set
  wire logic hardNow  = ctrl_reg[HCR_CTRL_ATTENTION_REQUEST_BIT] && ctrl_reg[HCR_CTRL_RST_BIT];
  wire logic adaRst   = hardRst_reg;

  // ==================================================
  // setup option registers; adapter hard reset does not touch setup state
  // these fields belong to the host's configuration pass, so only the host bus
  // reset returns them to their power-up values.
  // option register five packs three two-bit fields; window size sits at bits
  // three and two because bits four and five carry the interrupt level.
  // reserved bits of every option byte are dropped on write.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      opt_reg <= '{windowSizeSelect: HCR_WSZ_RESET, windowEnable: 1'b0,
                   arbitrationPriority: HCR_ARB_RESET, fairnessEnable: 1'b0,
                   onboardTransceiverSelect: 1'b0, burstBoundarySelect: HCR_BND_RESET,
                   irqLevelSelect: HCR_IRQ_RESET};
      sub_reg <= 16'h0000;
    end else if (clkEn && optWr) begin
      if (optWrArb) begin
        opt_reg.arbitrationPriority <= optWdata[3:0];
        opt_reg.fairnessEnable      <= optWdata[4];
      end else if (optAddr == HCR_OPT_XCVR) begin
        opt_reg.windowEnable             <= optWdata[0];
        opt_reg.onboardTransceiverSelect <= optWdata[1];
      end else if (optAddr == HCR_OPT_MISC) begin
        opt_reg.burstBoundarySelect <= optWdata[1:0];
        opt_reg.irqLevelSelect      <= optWdata[5:4];
        opt_reg.windowSizeSelect    <= optWdata[3:2];
      end else if (optAddr == HCR_OPT_SUBLO) begin
        sub_reg[7:0] <= optWdata;
      end else if (optAddr == HCR_OPT_SUBHI) begin
        sub_reg[15:8] <= optWdata;
      end
    end
  end

  // extended compare bytes at subaddresses 0100 to 0104
  // only the low three subaddress bits index the array; the range test above
  // guarantees the index stays inside the five entries.
  // the compare logic itself lives outside this block and reads baseCompareBits.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < HCR_CMP_COUNT; i++) cmp_reg[i] <= 8'h00;
    end else if (clkEn && optWrExt) begin
      cmp_reg[cmpIdx] <= optWdata;
    end
  end

  // option read: register three doubles as extended-space port
  // the prom is read combinationally through promAddr, so its data is settled
  // within the cycle of the strobe and captured with the other option bytes.
  // option register five reads back its two fixed high bits as ones.
  // unused subaddresses read as zero rather than floating.
  assign promAddr = sub_reg[7:0];
  wire logic [7:0] extData = subProm ? promData : (subCmp ? cmp_reg[cmpIdx] : 8'h00);
  wire logic [7:0] arbByte = {3'b000, opt_reg.fairnessEnable, opt_reg.arbitrationPriority};
  wire logic [7:0] xcvrByte = {6'b000000, opt_reg.onboardTransceiverSelect, opt_reg.windowEnable};
  wire logic [7:0] miscByte = {2'b11, opt_reg.irqLevelSelect, opt_reg.windowSizeSelect,
                               opt_reg.burstBoundarySelect};
  wire logic [7:0] optSel =
    (optAddr == HCR_OPT_ARB)   ? (subZero ? arbByte : extData) :
    (optAddr == HCR_OPT_XCVR)  ? xcvrByte :
    (optAddr == HCR_OPT_MISC)  ? miscByte :
    (optAddr == HCR_OPT_SUBLO) ? sub_reg[7:0] :
    (optAddr == HCR_OPT_SUBHI) ? sub_reg[15:8] : 8'h00;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) optRdata <= 8'h00;
    else if (clkEn && optRd) optRdata <= optSel;
  end

  // ==================================================
  // host control and page; cleared only by the host bus reset
  // the hard reset must not clear ctrl_reg: it is ctrl_reg that holds the
  // attention and reset bits, and clearing them would end the hard reset at once.
  // hard reset is registered, which costs one cycle of lag but keeps the
  // adapter reset free of decode glitches.
  // reserved control bits are masked off so they always read back as zero.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_reg <= 8'h00;
      page_reg <= 8'h00;
      hardRst_reg <= 1'b0;
    end else if (clkEn) begin
      if (hCtrlWr) ctrl_reg <= hostIo.data & HCR_CTRL_MASK;
      if (hPageWr) page_reg <= hostIo.data;
      hardRst_reg <= hardNow;
    end
  end

  // ==================================================
  // command register, two directions, with handshake flags
  // a write beats a read when both land in one cycle, so no byte is lost
  // the empty flag: a host write in the same cycle as a local read leaves the
  // new byte unread, so the register stays marked not empty.
  // the full flag: a local write in the cycle of a host read is a new byte,
  // so full stays set and the host interrupt is kept.
  // during the hard reset both flags sit at their idle values and command
  // bytes from either side are dropped.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      h2a_reg <= 8'h00;
      a2h_reg <= 8'h00;
      empty_reg <= 1'b1;
      full_reg <= 1'b0;
    end else if (clkEn) begin
      if (adaRst) begin
        empty_reg <= 1'b1;
        full_reg <= 1'b0;
      end else begin
        if (hCmdWr) h2a_reg <= hostIo.data;
        if (lpWr) a2h_reg <= lpWdata;
        if (lpRd && !hCmdWr) empty_reg <= 1'b1;
        else if (hCmdWr) empty_reg <= 1'b0;
        if (lpWr) full_reg <= 1'b1;
        else if (hCmdRd) full_reg <= 1'b0;
      end
    end
  end
  assign lpRdata = h2a_reg;

  // host read mux; reserved status bits read as zero
  // read data is captured on the strobe edge and then holds until the next
  // host read, so a slow host may sample it late without losing it.
  // unmapped offsets return zero.
  wire logic [7:0] statByte = {1'b0, empty_reg, full_reg, 5'b00000};
  wire logic [7:0] hostSel =
    (hostIo.addr == HCR_OFS_CMD)  ? a2h_reg :
    (hostIo.addr == HCR_OFS_STAT) ? statByte :
    (hostIo.addr == HCR_OFS_CTRL) ? ctrl_reg :
    (hostIo.addr == HCR_OFS_PAGE) ? page_reg : 8'h00;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) hostRdata <= 8'h00;
    else if (clkEn && hRd) hostRdata <= hostSel;
  end

  // ==================================================
  // side effects
  // attention alone gives nmi; with reset set it becomes the hard reset instead
  // both are levels: the local processor is expected to edge-detect the nmi.
  // the host interrupt is a level as well and drops when the host reads the
  // command byte or clears the enable bit.
  // the host bus must map hostIrqLevel onto the matching request line.
  assign adapterNmi       = ctrl_reg[HCR_CTRL_ATTENTION_REQUEST_BIT] && !ctrl_reg[HCR_CTRL_RST_BIT];
  assign adapterHardReset = hardRst_reg;
  assign hostIrq = full_reg && ctrl_reg[HCR_CTRL_IRQE_BIT];

  // ==================================================
  // decoded option outputs
  // window size code 11 is unsupported and decodes to zero kilobytes, which
  // also keeps the window closed in the hit test below.
  // burst boundary code 00 gives zero, meaning no forced release of the bus.
  // the interrupt level is a plain offset from level nine.
  assign opts = opt_reg;
  assign windowBytesK = (opt_reg.windowSizeSelect == 2'b00) ? 7'd16 :
                        (opt_reg.windowSizeSelect == 2'b01) ? 7'd32 :
                        (opt_reg.windowSizeSelect == 2'b10) ? 7'd64 : 7'd0;
  assign hostIrqLevel = 4'd9 + {2'b00, opt_reg.irqLevelSelect};
  assign burstBytes = (opt_reg.burstBoundarySelect == 2'b00) ? 7'd0 :
                      (opt_reg.burstBoundarySelect == 2'b01) ? 7'd16 :
                      (opt_reg.burstBoundarySelect == 2'b10) ? 7'd32 : 7'd64;
  assign baseCompareBits = {cmp_reg[4], cmp_reg[3], cmp_reg[2], cmp_reg[1], cmp_reg[0]};

  // ==================================================
  // host window into adapter memory, base on a 4K page boundary
  // the page register moves the window in 4K steps; the offset is added, not
  // or-ed, so a window larger than 4K still maps to contiguous memory.
  // the limit compares against the selected window size; accesses are ignored
  // until the window is enabled.
  // a window that runs past the top of adapter memory wraps at ADDR_W bits.
  wire logic [ADDR_W-1:0] pageBase = ADDR_W'({page_reg, 12'h000});
  wire logic [16:0] winLimit = {windowBytesK, 10'h000};
  wire logic inWin = {1'b0, winOffset} < winLimit;
  assign winHit = winReq && opt_reg.windowEnable && inWin;
  assign winAdapterAddr = pageBase + ADDR_W'(winOffset);

endmodule

// >>> testbench/hcr_prom_model.sv
// stand-in for the identification prom behind the subaddress port
`timescale 1ns/1ps
module hcr_prom_model (
  // lookup
  input  wire logic [7:0] promAddr,
  output logic      [7:0] promData
);
  // scrambled so an address echo cannot pass for prom data
  assign promData = promAddr ^ 8'hA5;
endmodule

// >>> testbench/hcr_asserts.sv
// concurrent checks on the host config register ports
`timescale 1ns/1ps
module hcr_asserts
  import hcr_pkg::*;
(
  // clock and reset
  input logic       clk,
  input logic       arst_n,
  input logic       clkEn,
  // host and local side
  input hcr_io_t    hostIo,
  input logic       lpWr,
  input logic [7:0] lpRdata,
  // decoded outputs
  input hcr_opt_t   opts,
  input logic [6:0] windowBytesK,
  input logic [3:0] hostIrqLevel,
  input logic [6:0] burstBytes,
  input logic       hostIrq,
  input logic       adapterNmi,
  input logic       adapterHardReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // option decoding
  a_irq_level: assert property (hostIrqLevel == 4'(9 + opts.irqLevelSelect))
    else $error("irq level decode");
  a_window_size: assert property (windowBytesK == ((opts.windowSizeSelect == 2'h3) ? 7'h00 : 7'(16 << opts.windowSizeSelect)))
    else $error("window size decode");
  a_burst_size: assert property (burstBytes == ((opts.burstBoundarySelect == 2'h0) ? 7'h00 : 7'(8 << opts.burstBoundarySelect)))
    else $error("burst boundary decode");
  a_reset_defaults: assert property ($rose(arst_n) |-> opts.arbitrationPriority == 4'hA && !opts.fairnessEnable && !opts.onboardTransceiverSelect)
    else $error("option reset values");
  // ==========================================================
  // command byte handshake and control side effects
  a_cmd_to_lp: assert property (hostIo.wr && hostIo.addr == 4'h0 && clkEn && !adapterHardReset |=> lpRdata == $past(hostIo.data))
    else $error("host byte not passed on");
  a_read_clears: assert property (hostIo.rd && hostIo.addr == 4'h0 && clkEn && !lpWr |=> !hostIrq)
    else $error("full flag kept after host read");
  a_nmi_soft: assert property (adapterNmi |=> !adapterHardReset)
    else $error("attention alone caused hard reset");
  a_hard_quiet: assert property (adapterHardReset [*2] |-> !hostIrq)
    else $error("irq during hard reset");
endmodule
bind host_config_regs hcr_asserts u_asserts (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
  .hostIo(hostIo), .lpWr(lpWr), .lpRdata(lpRdata), .opts(opts), .windowBytesK(windowBytesK),
  .hostIrqLevel(hostIrqLevel), .burstBytes(burstBytes), .hostIrq(hostIrq),
  .adapterNmi(adapterNmi), .adapterHardReset(adapterHardReset));

// >>> testbench/tb.sv
// self-checking bench for the host config register block
`timescale 1ns/1ps
module tb;
  import hcr_pkg::*;
  logic        clk, arst_n, clkEn, optWr, optRd, lpWr, lpRd, winReq, winHit;
  logic        hostIrq, adapterNmi, adapterHardReset;
  logic [2:0]  optAddr;
  logic [7:0]  optWdata, optRdata, promAddr, promData, hostRdata, lpWdata, lpRdata;
  hcr_io_t     hostIo;
  hcr_opt_t    opts;
  logic [15:0] winOffset;
  logic [19:0] winAdapterAddr;
  logic [6:0]  windowBytesK, burstBytes;
  logic [3:0]  hostIrqLevel;
  logic [39:0] baseCompareBits;
  int          errors, n_tests;
  // ==========================================================
  // design and prom stand-in
  host_config_regs DUT (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .optWr(optWr),
    .optRd(optRd), .optAddr(optAddr), .optWdata(optWdata), .optRdata(optRdata),
    .promAddr(promAddr), .promData(promData), .hostIo(hostIo), .hostRdata(hostRdata),
    .lpWr(lpWr), .lpRd(lpRd), .lpWdata(lpWdata), .lpRdata(lpRdata), .winReq(winReq),
    .winOffset(winOffset), .winHit(winHit), .winAdapterAddr(winAdapterAddr), .opts(opts),
    .windowBytesK(windowBytesK), .hostIrqLevel(hostIrqLevel), .burstBytes(burstBytes),
    .baseCompareBits(baseCompareBits), .hostIrq(hostIrq), .adapterNmi(adapterNmi),
    .adapterHardReset(adapterHardReset));
  hcr_prom_model u_prom (.promAddr(promAddr), .promData(promData));
  // ==========================================================
  // access tasks: strobe for one edge, sample just after the taking edge
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic io_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) hostIo <= '{1'b0, 1'b1, a, d};
    @(posedge clk) hostIo <= '0;
    #1;
  endtask
  task automatic io_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) hostIo <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk) hostIo <= '0;
    #1 chk(40'(hostRdata), 40'(exp));
  endtask
  task automatic opt_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) {optWr, optAddr, optWdata} <= {1'b1, a, d};
    @(posedge clk) optWr <= 1'b0;
    #1;
  endtask
  task automatic opt_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk) {optRd, optAddr} <= {1'b1, a};
    @(posedge clk) optRd <= 1'b0;
    #1 chk(40'(optRdata), 40'(exp));
  endtask
  task automatic lp_wr(input logic [7:0] d);
    @(posedge clk) {lpWr, lpWdata} <= {1'b1, d};
    @(posedge clk) lpWr <= 1'b0;
    #1;
  endtask
  task automatic finish_test;
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // free-running bus clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, optWr, optRd, optAddr, optWdata, lpWr, lpRd, lpWdata} = '0;
    {hostIo, winReq, winOffset, errors, n_tests} = '0;
    clkEn = 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    opt_rd(3'h3, 8'h0A);
    io_rd(4'h2, 8'h40);
    io_rd(4'h6, 8'h00);
    io_rd(4'h4, 8'h00);
    // both directions in the same cycle
    fork
      io_wr(4'h0, 8'h5A);
      lp_wr(8'hC3);
    join
    chk(40'(lpRdata), 40'h5A);
    chk(40'(hostIrq), 40'h0);
    io_rd(4'h2, 8'h20);
    @(posedge clk) lpRd <= 1'b1;
    @(posedge clk) lpRd <= 1'b0;
    io_rd(4'h2, 8'h60);
    io_wr(4'h6, 8'h08);
    chk(40'(hostIrq), 40'h1);
    io_rd(4'h0, 8'hC3);
    io_rd(4'h2, 8'h40);
    // reserved control bits, hard reset, then attention alone
    io_wr(4'h6, 8'hFF);
    io_rd(4'h6, 8'hC8);
    chk(40'({adapterHardReset, adapterNmi}), 40'h2);
    io_wr(4'h6, 8'h80);
    io_rd(4'h6, 8'h80);
    chk(40'({adapterHardReset, adapterNmi}), 40'h1);
    io_wr(4'h6, 8'h00);
    io_wr(4'h2, 8'hFF);
    io_rd(4'h2, 8'h40);
    // page register and shared window
    @(posedge clk) {winReq, winOffset} <= {1'b1, 16'h0123};
    io_wr(4'h8, 8'h38);
    chk(40'(winAdapterAddr), 40'h38123);
    chk(40'(winHit), 40'h0);
    opt_wr(3'h4, 8'h03);
    chk(40'({winHit, opts.onboardTransceiverSelect}), 40'h3);
    io_wr(4'h8, 8'h00);
    chk(40'(winAdapterAddr), 40'h00123);
    // clock enable low: a page write must not land
    @(posedge clk) clkEn <= 1'b0;
    io_wr(4'h8, 8'h55);
    @(posedge clk) clkEn <= 1'b1;
    io_rd(4'h8, 8'h00);
    // every code of the three fields in option register five
    for (int i = 0; i < 4; i++) begin
      opt_wr(3'h5, 8'(i * 8'h15));
      chk(40'(hostIrqLevel), 40'(9 + i));
      chk(40'(burstBytes), 40'((i == 0) ? 0 : (8 << i)));
      chk(40'(windowBytesK), 40'((i == 3) ? 0 : (16 << i)));
    end
    opt_wr(3'h3, 8'h1C);
    chk(40'({opts.arbitrationPriority, opts.fairnessEnable}), 40'h19);
    // subaddress port: prom range then compare bits
    opt_wr(3'h6, 8'h10);
    opt_rd(3'h3, 8'hB5);
    opt_wr(3'h3, 8'h55);
    opt_rd(3'h3, 8'hB5);
    opt_wr(3'h6, 8'h00);
    opt_wr(3'h7, 8'h01);
    opt_wr(3'h3, 8'h77);
    chk(40'(baseCompareBits[7:0]), 40'h77);
    opt_wr(3'h7, 8'h00);
    opt_rd(3'h3, 8'h1C);
    finish_test();
  end
endmodule
